// ---- include/cscb_pkg.sv ----
// ==========================================================
// shared constants and carriers for the cpu status bits
package cscb_pkg;

  // ========================================================
  // bit positions in status word two
  localparam int unsigned CSCB_EMU_POS = 11;
  localparam int unsigned CSCB_RND_POS = 10;

  // ========================================================
  // bit positions in status word three
  localparam int unsigned CSCB_LOCK_POS = 15;
  localparam int unsigned CSCB_ON_POS = 14;
  localparam int unsigned CSCB_FLUSH_POS = 13;
  localparam int unsigned CSCB_HIRQ_POS = 12;
  localparam int unsigned CSCB_FAULT_POS = 7;
  localparam int unsigned CSCB_ROM_POS = 6;
  localparam int unsigned CSCB_CLKDIS_POS = 2;

  // ========================================================
  // reset values
  localparam logic CSCB_EMU_RST = 1'b0;
  localparam logic CSCB_RND_RST = 1'b0;
  localparam logic CSCB_LOCK_RST = 1'b0;
  localparam logic CSCB_ON_RST = 1'b0;
  localparam logic CSCB_FLUSH_RST = 1'b0;
  localparam logic CSCB_HIRQ_RST = 1'b1;
  localparam logic CSCB_FAULT_RST = 1'b0;
  localparam logic CSCB_ROM_RST = 1'b0;
  localparam logic CSCB_CLKDIS_RST = 1'b0;

  // ========================================================
  // word selectors and rounding constants
  localparam logic CSCB_SEL_TWO = 1'b0;
  localparam logic CSCB_SEL_THREE = 1'b1;
  localparam int unsigned CSCB_ACC_W = 40;
  localparam logic [15:0] CSCB_HALF = 16'h8000;
  localparam logic [39:0] CSCB_HALF_40 = 40'h0000008000;

  // single-bit set or clear of a status bit
  typedef struct packed {
    logic valid;
    logic word;
    logic [3:0] idx;
    logic val;
  } cscb_bitop_t;

  // whole-word write of a status word
  typedef struct packed {
    logic valid;
    logic word;
    logic [15:0] data;
  } cscb_wr_t;

  // rounding request toward the d unit
  typedef struct packed {
    logic valid;
    logic legacy_compat_mode;
    logic [39:0] operand;
  } cscb_rnd_t;

  // whole state of the block
  typedef struct packed {
    logic emu_write_allow;
    logic round_mode_sel;
    logic cache_lock;
    logic cache_on;
    logic cache_flush_req;
    logic host_irq_ctrl;
    logic bus_fault_flag;
    logic rom_map_select;
    logic clock_output_disable;
    logic clk_out;
    logic strap_load;
    logic ibq_flush;
    logic fault_irq;
    logic [15:0] push;
    logic [39:0] res;
    logic res_valid;
  } cscb_state_t;

endpackage

// ---- rtl/cscb_status_bits.sv ----
`timescale 1ns/1ns
`default_nettype none
module cscb_status_bits
  import cscb_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire cscb_bitop_t bitop_i,
  input wire cscb_wr_t wr_i,
  input wire logic irq_enter_i,
  input wire logic reti_i,
  input wire logic [15:0] stack_st2_i,
  input wire logic sw_reset_i,
  input wire logic bus_err_i,
  input wire logic flush_done_i,
  input wire logic rom_strap_i,
  input wire cscb_rnd_t rnd_i,
  output logic [15:0] st2_o,
  output logic [15:0] st3_o,
  output logic [15:0] st2_push_o,
  output logic emu_write_allow_o,
  output logic round_mode_sel_o,
  output logic cache_on_o,
  output logic cache_lock_o,
  output logic cache_flush_o,
  output logic ibq_flush_o,
  output logic bus_fault_flag_o,
  output logic bus_fault_irq_o,
  output logic clock_output_disable_o,
  output logic clock_output_pin_o,
  output logic host_irq_n_o,
  output logic rom_map_select_o,
  output logic [39:0] round_result_o,
  output logic round_valid_o
);

  // ========================================================
  // word images
  function automatic logic [15:0] img_two(input cscb_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[CSCB_EMU_POS] = s.emu_write_allow;
    w[CSCB_RND_POS] = s.round_mode_sel;
    return w;
  endfunction

  function automatic logic [15:0] img_three(input cscb_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[CSCB_LOCK_POS] = s.cache_lock;
    w[CSCB_ON_POS] = s.cache_on;
    w[CSCB_FLUSH_POS] = s.cache_flush_req;
    w[CSCB_HIRQ_POS] = s.host_irq_ctrl;
    w[CSCB_FAULT_POS] = s.bus_fault_flag;
    w[CSCB_ROM_POS] = s.rom_map_select;
    w[CSCB_CLKDIS_POS] = s.clock_output_disable;
    return w;
  endfunction

  // software update of one word: whole write first, then bit op
  // the bit op lands last, so it overrides the same bit of a word written in that cycle
  function automatic logic [15:0] sw_apply(input logic [15:0] w, input logic sel,
                                           input cscb_wr_t wr, input cscb_bitop_t bo);
    logic [15:0] r;
    r = w;
    if (wr.valid && wr.word == sel) begin
      r = wr.data;
    end
    if (bo.valid && bo.word == sel) begin
      r[bo.idx] = bo.val;
    end
    return r;
  endfunction

  // ========================================================
  // rounding
  // legacy code wants the low half back, so it is only cleared outside that mode
  function automatic logic [39:0] do_round(input cscb_rnd_t rq, input logic mode);
    logic add;
    logic [39:0] sum;
    add = 1'b1;
    if (mode) begin
      add = (rq.operand[15:0] > CSCB_HALF) ||
            (rq.operand[15:0] == CSCB_HALF && rq.operand[16]);
    end
    sum = add ? rq.operand + CSCB_HALF_40 : rq.operand;
    if (!rq.legacy_compat_mode) begin
      sum[15:0] = 16'h0000;
    end
    return sum;
  endfunction

  // all state sits in one struct so that ce_i freezes it in one place
  cscb_state_t cur;
  cscb_state_t next_cur;

  // ========================================================
  // next state
  always_comb begin
    logic [15:0] w2;
    logic [15:0] w3;
    logic sw_flush;
    w2 = sw_apply(img_two(cur), CSCB_SEL_TWO, wr_i, bitop_i);
    w3 = sw_apply(img_three(cur), CSCB_SEL_THREE, wr_i, bitop_i);
    sw_flush = w3[CSCB_FLUSH_POS] && !cur.cache_flush_req;
    next_cur = cur;
    next_cur.emu_write_allow = w2[CSCB_EMU_POS];
    next_cur.round_mode_sel = w2[CSCB_RND_POS];
    next_cur.cache_lock = w3[CSCB_LOCK_POS];
    next_cur.cache_on = w3[CSCB_ON_POS];
    next_cur.host_irq_ctrl = w3[CSCB_HIRQ_POS];
    next_cur.rom_map_select = w3[CSCB_ROM_POS];
    next_cur.clock_output_disable = w3[CSCB_CLKDIS_POS];
    // a request set while the flush is still pending is dropped, so the self-clear wins in the done cycle
    next_cur.cache_flush_req = sw_flush || (cur.cache_flush_req && !flush_done_i);
    // software can only clear the fault; a fresh error wins over the clear
    next_cur.bus_fault_flag = (cur.bus_fault_flag && w3[CSCB_FAULT_POS]) || bus_err_i;
    next_cur.fault_irq = bus_err_i;
    // software reset puts round, cache lock, cache on, host irq and clock disable bits back but leaves rom mapping alone
    if (sw_reset_i) begin
      next_cur.round_mode_sel = CSCB_RND_RST;
      next_cur.cache_lock = CSCB_LOCK_RST;
      next_cur.cache_on = CSCB_ON_RST;
      next_cur.host_irq_ctrl = CSCB_HIRQ_RST;
      next_cur.clock_output_disable = CSCB_CLKDIS_RST;
    end
    // return restores, entry saves and then clears
    if (reti_i) begin
      next_cur.emu_write_allow = stack_st2_i[CSCB_EMU_POS];
    end
    if (irq_enter_i) begin
      next_cur.push = img_two(cur);
      next_cur.emu_write_allow = 1'b0;
    end
    // strap is sampled once, at the first enabled edge after reset
    if (cur.strap_load) begin
      next_cur.rom_map_select = rom_strap_i;
      next_cur.strap_load = 1'b0;
    end
    // one-cycle queue flush on a new cache flush or on the cache being switched off
    next_cur.ibq_flush = (next_cur.cache_flush_req && !cur.cache_flush_req) ||
                         (cur.cache_on && !next_cur.cache_on);
    // pin runs at half the clock and parks low when disabled, so no runt pulse is left
    next_cur.clk_out = next_cur.clock_output_disable ? 1'b0 : !cur.clk_out;
    // rounding takes the mode as it stood before this edge
    next_cur.res_valid = rnd_i.valid;
    if (rnd_i.valid) begin
      next_cur.res = do_round(rnd_i, cur.round_mode_sel);
    end
  end

  // ========================================================
  // state register, frozen while ce_i is low
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
      cur.emu_write_allow <= CSCB_EMU_RST;
      cur.round_mode_sel <= CSCB_RND_RST;
      cur.cache_lock <= CSCB_LOCK_RST;
      cur.cache_on <= CSCB_ON_RST;
      cur.cache_flush_req <= CSCB_FLUSH_RST;
      cur.host_irq_ctrl <= CSCB_HIRQ_RST;
      cur.bus_fault_flag <= CSCB_FAULT_RST;
      cur.rom_map_select <= CSCB_ROM_RST;
      cur.clock_output_disable <= CSCB_CLKDIS_RST;
      // arms the one-time rom map load from the configuration pin
      cur.strap_load <= 1'b1;
    end else if (ce_i) begin
      cur <= next_cur;
    end
  end

  // ========================================================
  // outputs straight from the state register
  assign st2_o = img_two(cur);
  assign st3_o = img_three(cur);
  assign st2_push_o = cur.push;
  assign emu_write_allow_o = cur.emu_write_allow;
  assign round_mode_sel_o = cur.round_mode_sel;
  assign cache_on_o = cur.cache_on;
  assign cache_lock_o = cur.cache_lock;
  assign cache_flush_o = cur.cache_flush_req;
  assign ibq_flush_o = cur.ibq_flush;
  assign bus_fault_flag_o = cur.bus_fault_flag;
  assign bus_fault_irq_o = cur.fault_irq;
  assign clock_output_disable_o = cur.clock_output_disable;
  assign clock_output_pin_o = cur.clk_out;
  // the pin is the bit itself: clear then set gives the low pulse to the host
  assign host_irq_n_o = cur.host_irq_ctrl;
  assign rom_map_select_o = cur.rom_map_select;
  assign round_result_o = cur.res;
  assign round_valid_o = cur.res_valid;

  // ========================================================
  // checks
  emu_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && irq_enter_i |=> !emu_write_allow_o)
    else $error("entry did not clear write allow");

  emu_push_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && irq_enter_i |=> st2_push_o[11] == $past(emu_write_allow_o))
    else $error("pushed word lost write allow");

  emu_restore_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && reti_i && !irq_enter_i |=> emu_write_allow_o == $past(stack_st2_i[11]))
    else $error("return did not restore write allow");

  fault_set_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && bus_err_i |=> bus_fault_flag_o && bus_fault_irq_o)
    else $error("bus error not flagged");

  fault_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && !bus_err_i && !bus_fault_flag_o |=> !bus_fault_flag_o)
    else $error("fault flag set by software");

  flush_queue_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(cache_flush_o) |-> ibq_flush_o)
    else $error("flush without queue flush");

  cache_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    $fell(cache_on_o) |-> ibq_flush_o)
    else $error("cache disable without queue flush");

  round_inf_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && rnd_i.valid && !round_mode_sel_o && !rnd_i.legacy_compat_mode |=>
      round_result_o == {$past(rnd_i.operand[39:16]) + 24'h000001 * $past(rnd_i.operand[15]), 16'h0000})
    else $error("round to infinity wrong");

  round_low_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && rnd_i.valid && round_mode_sel_o && !rnd_i.legacy_compat_mode && !rnd_i.operand[15] |=>
      round_result_o == {$past(rnd_i.operand[39:16]), 16'h0000})
    else $error("round to nearest wrong");

  clk_off_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && clock_output_disable_o ##1 clock_output_disable_o |-> !clock_output_pin_o)
    else $error("clock pin runs while disabled");

  rom_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && sw_reset_i && !bitop_i.valid && !wr_i.valid && !$past(rst_i) |=> $stable(rom_map_select_o))
    else $error("software reset moved rom map");

  // ========================================================
  // checks on the cache bits
  // flush bit is set by software and only flush_done_i may clear it
  flush_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && cache_flush_o && !flush_done_i |=> cache_flush_o)
    else $error("flush bit dropped before done");

  flush_end_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && cache_flush_o && flush_done_i |=> !cache_flush_o)
    else $error("flush bit kept after done");

  lock_op_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && bitop_i.valid && bitop_i.word == CSCB_SEL_THREE && bitop_i.idx == 4'(CSCB_LOCK_POS) &&
      !sw_reset_i |=> cache_lock_o == $past(bitop_i.val))
    else $error("freeze bit not taken");

  cache_op_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && bitop_i.valid && bitop_i.word == CSCB_SEL_THREE && bitop_i.idx == 4'(CSCB_ON_POS) &&
      !sw_reset_i |=> cache_on_o == $past(bitop_i.val))
    else $error("cache enable bit not taken");

  // ========================================================
  // checks on the fault, clock, host and rom bits
  fault_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && bitop_i.valid && bitop_i.word == CSCB_SEL_THREE && bitop_i.idx == 4'(CSCB_FAULT_POS) &&
      !bitop_i.val && !bus_err_i |=> !bus_fault_flag_o)
    else $error("fault flag not cleared by zero");

  fault_irq_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && !bus_err_i |=> !bus_fault_irq_o)
    else $error("fault irq without bus error");

  clk_run_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && !clock_output_disable_o ##1 !clock_output_disable_o |-> clock_output_pin_o != $past(clock_output_pin_o))
    else $error("clock pin stuck while enabled");

  clk_dis_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && bitop_i.valid && bitop_i.word == CSCB_SEL_THREE && bitop_i.idx == 4'(CSCB_CLKDIS_POS) &&
      !sw_reset_i |=> clock_output_disable_o == $past(bitop_i.val))
    else $error("clock disable bit not taken");

  host_op_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && bitop_i.valid && bitop_i.word == CSCB_SEL_THREE && bitop_i.idx == 4'(CSCB_HIRQ_POS) &&
      !sw_reset_i |=> host_irq_n_o == $past(bitop_i.val))
    else $error("host irq bit not taken");

  rom_op_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && bitop_i.valid && bitop_i.word == CSCB_SEL_THREE && bitop_i.idx == 4'(CSCB_ROM_POS) &&
      !$past(rst_i) |=> rom_map_select_o == $past(bitop_i.val))
    else $error("rom map bit not taken");

  // ========================================================
  // checks on the emulation bit and rounding
  // each case names its own expected value, none is read back from do_round
  emu_op_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && bitop_i.valid && bitop_i.word == CSCB_SEL_TWO && bitop_i.idx == 4'(CSCB_EMU_POS) &&
      !reti_i && !irq_enter_i |=> emu_write_allow_o == $past(bitop_i.val))
    else $error("write allow bit not taken");

  push_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && !irq_enter_i |=> $stable(st2_push_o))
    else $error("saved word two moved without entry");

  round_tie_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && rnd_i.valid && round_mode_sel_o && !rnd_i.legacy_compat_mode && rnd_i.operand[15:0] == CSCB_HALF |=>
      round_result_o == {$past(rnd_i.operand[39:16]) + {23'h000000, $past(rnd_i.operand[16])}, 16'h0000})
    else $error("tie rounding wrong");

  round_high_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && rnd_i.valid && round_mode_sel_o && !rnd_i.legacy_compat_mode && rnd_i.operand[15:0] > CSCB_HALF |=>
      round_result_o == {$past(rnd_i.operand[39:16]) + 24'h000001, 16'h0000})
    else $error("round up above half wrong");

  round_keep_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && rnd_i.valid && rnd_i.legacy_compat_mode |=> round_result_o[14:0] == $past(rnd_i.operand[14:0]))
    else $error("legacy rounding cleared low bits");

  round_valid_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i |=> round_valid_o == $past(rnd_i.valid))
    else $error("round valid out of step");

endmodule
`default_nettype wire

// ---- tb/cscb_status_bits_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module cscb_status_bits_tb_top import cscb_pkg::*; ;
  // ======================================================
  // stimulus and observed signals
  logic mclk_i, rst_i, ce_i, irq_enter_i, reti_i, sw_reset_i, bus_err_i, flush_done_i, rom_strap_i;
  cscb_bitop_t bitop_i;
  cscb_wr_t wr_i;
  cscb_rnd_t rnd_i;
  logic [15:0] stack_st2_i, st2_o, st3_o, st2_push_o;
  logic emu_write_allow_o, round_mode_sel_o, cache_on_o, cache_lock_o, cache_flush_o, ibq_flush_o;
  logic bus_fault_flag_o, bus_fault_irq_o, clock_output_disable_o, clock_output_pin_o;
  logic host_irq_n_o, rom_map_select_o, round_valid_o, p;
  logic [39:0] round_result_o;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  // tie cases: below, above, odd tie, even tie
  logic [39:0] ops [4] = '{40'h0012347fff, 40'h0012348001, 40'h0012358000, 40'h0012348000};

  cscb_status_bits dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .bitop_i(bitop_i), .wr_i(wr_i),
    .irq_enter_i(irq_enter_i), .reti_i(reti_i), .stack_st2_i(stack_st2_i), .sw_reset_i(sw_reset_i),
    .bus_err_i(bus_err_i), .flush_done_i(flush_done_i), .rom_strap_i(rom_strap_i), .rnd_i(rnd_i),
    .st2_o(st2_o), .st3_o(st3_o), .st2_push_o(st2_push_o), .emu_write_allow_o(emu_write_allow_o),
    .round_mode_sel_o(round_mode_sel_o), .cache_on_o(cache_on_o), .cache_lock_o(cache_lock_o),
    .cache_flush_o(cache_flush_o), .ibq_flush_o(ibq_flush_o), .bus_fault_flag_o(bus_fault_flag_o),
    .bus_fault_irq_o(bus_fault_irq_o), .clock_output_disable_o(clock_output_disable_o),
    .clock_output_pin_o(clock_output_pin_o), .host_irq_n_o(host_irq_n_o),
    .rom_map_select_o(rom_map_select_o), .round_result_o(round_result_o), .round_valid_o(round_valid_o));

  // ======================================================
  // clock and hang guard
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // the whole run needs well under 200 cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      wrap_up();
    end
  end

  // ======================================================
  // compare and access tasks
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: bit %b not %b", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask
  // requests wait for a falling edge, go up, and drop at the next one, so exactly one
  // rising edge takes them and back-to-back calls never reassign a signal in one step
  task automatic bit_op(input logic w, input logic [3:0] idx, input logic v);
    @(negedge mclk_i);
    bitop_i = '{1'b1, w, idx, v};
    @(negedge mclk_i);
    bitop_i = '0;
  endtask
  task automatic wr_word(input logic w, input logic [15:0] d);
    @(negedge mclk_i);
    wr_i = '{1'b1, w, d};
    @(negedge mclk_i);
    wr_i = '0;
  endtask
  // m selects irq_enter, reti, sw_reset, bus_err, flush_done from the top bit down
  task automatic pulse(input logic [4:0] m);
    @(negedge mclk_i);
    {irq_enter_i, reti_i, sw_reset_i, bus_err_i, flush_done_i} = m;
    @(negedge mclk_i);
    {irq_enter_i, reti_i, sw_reset_i, bus_err_i, flush_done_i} = 5'h00;
  endtask
  // expected result built from the mode table, not from the design
  task automatic rnd(input logic mode, input logic leg, input logic [39:0] op);
    logic [39:0] e;
    logic add;
    add = !mode || op[15:0] > 16'h8000 || (op[15:0] == 16'h8000 && op[16]);
    e = add ? op + 40'h0000008000 : op;
    if (!leg) e[15:0] = 16'h0000;
    @(negedge mclk_i);
    rnd_i = '{1'b1, leg, op};
    @(negedge mclk_i);
    rnd_i = '0;
    chk_bit(round_valid_o, 1'b1);
    chk_val(round_result_o, e);
  endtask
  task automatic wrap_up();
    if (fails == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ======================================================
  // main sequence
  initial begin
    {rst_i, ce_i, rom_strap_i} = 3'h7;
    {irq_enter_i, reti_i, sw_reset_i, bus_err_i, flush_done_i} = 5'h00;
    bitop_i = '0;
    wr_i = '0;
    rnd_i = '0;
    stack_st2_i = 16'h0000;
    repeat (20) @(negedge mclk_i);
    chk_val({24'h000000, st3_o}, 40'h1000);
    chk_val({24'h000000, st2_o}, 40'h0000);
    rst_i = 1'b0;
    @(negedge mclk_i);
    chk_bit(rom_map_select_o, 1'b1);
    pulse(5'h04);
    chk_bit(rom_map_select_o, 1'b1);
    bit_op(1'b1, 4'h6, 1'b0);
    chk_bit(rom_map_select_o, 1'b0);
    // emulation write allow saved, cleared on entry, restored on return
    bit_op(1'b0, 4'hb, 1'b1);
    chk_val({24'h000000, st2_o}, 40'h0800);
    pulse(5'h10);
    chk_val({24'h000000, st2_push_o}, 40'h0800);
    chk_bit(emu_write_allow_o, 1'b0);
    stack_st2_i = 16'h0800;
    pulse(5'h08);
    chk_bit(emu_write_allow_o, 1'b1);
    // rounding in both modes, with and without legacy mode
    wr_word(1'b0, 16'h0000);
    rnd(1'b0, 1'b0, 40'h0012347fff);
    rnd(1'b0, 1'b1, 40'h0012348000);
    wr_word(1'b0, 16'h0400);
    chk_bit(round_mode_sel_o, 1'b1);
    for (int i = 0; i < 4; i++) rnd(1'b1, 1'b0, ops[i]);
    rnd(1'b1, 1'b1, 40'h0012348001);
    // cache enable, queue flush, cache flush and freeze
    bit_op(1'b1, 4'he, 1'b1);
    chk_bit(cache_on_o, 1'b1);
    bit_op(1'b1, 4'he, 1'b0);
    chk_bit(ibq_flush_o, 1'b1);
    chk_bit(cache_on_o, 1'b0);
    @(negedge mclk_i);
    chk_bit(ibq_flush_o, 1'b0);
    bit_op(1'b1, 4'hd, 1'b1);
    chk_bit(ibq_flush_o, 1'b1);
    bit_op(1'b1, 4'hd, 1'b0);
    chk_bit(cache_flush_o, 1'b1);
    pulse(5'h01);
    chk_bit(cache_flush_o, 1'b0);
    bit_op(1'b1, 4'hf, 1'b1);
    chk_bit(cache_lock_o, 1'b1);
    // bus fault flag: set by error, write of 1 ignored, write of 0 clears
    pulse(5'h02);
    chk_bit(bus_fault_flag_o, 1'b1);
    chk_bit(bus_fault_irq_o, 1'b1);
    bit_op(1'b1, 4'h7, 1'b0);
    chk_bit(bus_fault_flag_o, 1'b0);
    bit_op(1'b1, 4'h7, 1'b1);
    chk_bit(bus_fault_flag_o, 1'b0);
    // clock pin toggles, then stays low once disabled
    p = clock_output_pin_o;
    @(negedge mclk_i);
    chk_bit(clock_output_pin_o, !p);
    bit_op(1'b1, 4'h2, 1'b1);
    chk_bit(clock_output_disable_o, 1'b1);
    repeat (2) @(negedge mclk_i);
    chk_bit(clock_output_pin_o, 1'b0);
    // host interrupt pulse by clear then set
    bit_op(1'b1, 4'hc, 1'b0);
    chk_bit(host_irq_n_o, 1'b0);
    bit_op(1'b1, 4'hc, 1'b1);
    chk_bit(host_irq_n_o, 1'b1);
    // with ce_i low a cache enable request is ignored
    ce_i = 1'b0;
    bit_op(1'b1, 4'he, 1'b1);
    chk_bit(cache_on_o, 1'b0);
    ce_i = 1'b1;
    // reset in mid-run clears a raised fault and reloads the rom map from the pin
    pulse(5'h02);
    {rst_i, rom_strap_i} = 2'h2;
    @(negedge mclk_i);
    chk_bit(bus_fault_flag_o, 1'b0);
    rst_i = 1'b0;
    @(negedge mclk_i);
    chk_bit(rom_map_select_o, 1'b0);
    chk_val({24'h000000, st3_o}, 40'h1000);
    wrap_up();
  end
endmodule
`default_nettype wire
